// >>> dmiv_pkg.sv
// Package of constants and carrier types for the DMA interrupt vector block.
package dmiv_pkg;

	// ----------------------------------------------------------------
	// Sizes and codes
	// ----------------------------------------------------------------
	localparam int          DMIV_CHANNELS   = 8;
	localparam int          DMIV_CNT_W      = 16;
	localparam int          DMIV_VEC_W      = 16;
	localparam int          DMIV_SLOTS      = 16;
	localparam logic [15:0] DMIV_VEC_NONE   = 16'h0000;
	localparam logic [15:0] DMIV_VEC_STEP   = 16'h0002;
	localparam logic [1:0]  DMIV_SEQ_SINGLE = 2'h0;
	localparam logic [1:0]  DMIV_SEQ_MULTI  = 2'h1;
	localparam logic [1:0]  DMIV_SEQ_RPT_1  = 2'h2;
	localparam logic [1:0]  DMIV_SEQ_RPT_N  = 2'h3;

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	// One access to the vector word by the CPU.
	typedef struct packed {
		logic rd;
		logic wr;
	} dmiv_vec_acc_t;

	// One data move completed by the transfer engine on a channel.
	typedef struct packed {
		logic                          valid;
		logic [$clog2(DMIV_CHANNELS)-1:0] chan;
		logic [DMIV_CNT_W-1:0]         count_after;
		logic                          to_dac;
		logic                          from_slot;
		logic [$clog2(DMIV_SLOTS)-1:0] slot;
	} dmiv_move_t;

endpackage

// >>> dmiv_prio.sv
// Fixed-priority encoder turning enabled pending flags into a vector code.
`timescale 1ns/1ps
module dmiv_prio
	import dmiv_pkg::*;
#(
	parameter int N = DMIV_CHANNELS
) (
	// Requests
	input  wire logic [N-1:0]          req,
	// Result
	output logic [N-1:0]               onehot,
	output logic [DMIV_VEC_W-1:0]      code
);

	always_comb begin
		onehot = '0;
		code   = DMIV_VEC_NONE;
		// Lowest index wins; scanning downward leaves it last.
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i]) begin
				onehot    = '0;
				onehot[i] = 1'b1;
				code      = DMIV_VEC_W'((i + 1) * DMIV_VEC_STEP);
			end
		end
	end

endmodule

// >>> dmiv_top.sv
// Completion flags, interrupt request, vector word and peripheral flag clears.
// Notes on behaviour
// - flag sets when channel count reaches zero.
// - request needs flag, channel and global enable.
// - channel zero highest, fixed descending priority.
// - vector ignores disabled pending flags.
// - codes zero, else two times channel plus two.
// - any vector access clears reported flag.
// - next enabled flag reported and requested immediately.
// - DMA slot access clears converter result flag.
// - DMA converter data write clears its flag.
// - moves need no CPU, any power mode.
`timescale 1ns/1ps
module dmiv_top
	import dmiv_pkg::*;
#(
	parameter int N     = DMIV_CHANNELS,
	parameter int SLOTS = DMIV_SLOTS
) (
	// Clock and reset
	input  wire logic                    ref_clk,
	input  wire logic                    srst,
	// CPU side
	input  wire logic [N-1:0]            chan_irq_enable,
	input  wire logic                    global_irq_enable,
	input  wire dmiv_vec_acc_t           vec_acc,
	output logic [N-1:0]                 chan_done_flag,
	output logic [DMIV_VEC_W-1:0]        irq_vector_word,
	output logic                         irq_req,
	// Transfer engine side
	input  wire dmiv_move_t              move,
	// Converter and serial unit side
	input  wire logic [1:0]              conv_sequence_mode,
	input  wire logic [$clog2(SLOTS)-1:0] conv_last_slot,
	input  wire logic [SLOTS-1:0]        conv_result_flag,
	input  wire logic                    dac_ready_flag,
	input  wire logic                    i2c_rx_ready,
	input  wire logic                    i2c_tx_needed,
	output logic [SLOTS-1:0]             conv_result_flag_clr,
	output logic                         dac_ready_flag_clr,
	output logic                         conv_trigger,
	output logic                         dac_trigger,
	output logic                         i2c_rx_trigger,
	output logic                         i2c_tx_trigger
);

	// ----------------------------------------------------------------
	// Widths and local signals
	// ----------------------------------------------------------------
	localparam int SLOT_W = $clog2(SLOTS);

	logic [N-1:0]            flag_q;
	logic [N-1:0]            flag_d;
	logic [N-1:0]            enabled_pending;
	logic [N-1:0]            win_onehot;
	logic [N-1:0]            set_vec;
	logic [N-1:0]            next_onehot;
	logic [DMIV_VEC_W-1:0]   next_code;
	logic [SLOTS-1:0]        slot_hit;
	logic [SLOT_W-1:0]       trig_slot;
	logic                    vec_touch;
	logic                    move_done;
	logic                    multi_seq;

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	// Next flag state; a set in the clearing cycle wins over the clear.
	function automatic logic [N-1:0] next_flags(
		input logic [N-1:0] cur,
		input logic [N-1:0] win,
		input logic         touch,
		input logic [N-1:0] set
	);
		next_flags = (cur & ~(win & {N{touch}})) | set;
	endfunction

	// True when an index names the decoder output at the given position.
	function automatic logic index_is(
		input logic [7:0] idx,
		input int         pos
	);
		index_is = (idx == 8'(pos));
	endfunction

	// ----------------------------------------------------------------
	// Completion flags
	// ----------------------------------------------------------------
	assign vec_touch       = vec_acc.rd | vec_acc.wr;
	assign enabled_pending = flag_q & chan_irq_enable;
	assign move_done       = move.valid && (move.count_after == '0);

	// Set comes from the engine whatever the transfer mode, with no CPU involved.
	for (genvar c = 0; c < N; c++) begin : g_set
		assign set_vec[c] = move_done && index_is(8'(move.chan), c);
	end

	dmiv_prio #(
		.N (N)
	) u_prio (
		.req    (enabled_pending),
		.onehot (win_onehot),
		.code   ()
	);

	assign flag_d = next_flags(flag_q, win_onehot, vec_touch, set_vec);

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			flag_q <= '0;
		end else begin
			flag_q <= flag_d;
		end
	end

	// ----------------------------------------------------------------
	// Vector word
	// ----------------------------------------------------------------
	// The second encoder looks ahead so that the registered vector follows the flags.
	dmiv_prio #(
		.N (N)
	) u_prio_next (
		.req    (flag_d & chan_irq_enable),
		.onehot (next_onehot),
		.code   (next_code)
	);

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			irq_vector_word <= DMIV_VEC_NONE;
		end else begin
			irq_vector_word <= next_code;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt request
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			irq_req <= 1'b0;
		end else begin
			irq_req <= global_irq_enable && (next_onehot != '0);
		end
	end

	// ----------------------------------------------------------------
	// Flag outputs
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			chan_done_flag <= '0;
		end else begin
			chan_done_flag <= flag_d;
		end
	end

	// ----------------------------------------------------------------
	// Converter result flag clears
	// ----------------------------------------------------------------
	for (genvar s = 0; s < SLOTS; s++) begin : g_slot
		assign slot_hit[s] = move.valid && move.from_slot && index_is(8'(move.slot), s);
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			conv_result_flag_clr <= '0;
		end else begin
			conv_result_flag_clr <= slot_hit;
		end
	end

	// ----------------------------------------------------------------
	// Converter data flag clear
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			dac_ready_flag_clr <= 1'b0;
		end else begin
			dac_ready_flag_clr <= move.valid && move.to_dac;
		end
	end

	// ----------------------------------------------------------------
	// Converter trigger
	// ----------------------------------------------------------------
	assign multi_seq = (conv_sequence_mode == DMIV_SEQ_MULTI) ||
	                   (conv_sequence_mode == DMIV_SEQ_RPT_N);
	// In single modes the converter reports the slot in use on the same port.
	assign trig_slot = conv_last_slot;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			conv_trigger <= 1'b0;
		end else begin
			conv_trigger <= multi_seq ? conv_result_flag[trig_slot]
			                          : conv_result_flag[trig_slot];
		end
	end

	// ----------------------------------------------------------------
	// Data converter and serial unit triggers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			dac_trigger <= 1'b0;
		end else begin
			dac_trigger <= dac_ready_flag;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			i2c_rx_trigger <= 1'b0;
			i2c_tx_trigger <= 1'b0;
		end else begin
			i2c_rx_trigger <= i2c_rx_ready;
			i2c_tx_trigger <= i2c_tx_needed;
		end
	end

endmodule

// >>> dmiv_top_sva.sv
// Port assertions for the DMA interrupt vector block.
`timescale 1ns/1ps
module dmiv_top_sva
	import dmiv_pkg::*;
#(
	parameter int N = 8,
	parameter int SLOTS = 16
) (
	// Clock, reset and CPU side
	input wire logic		ref_clk,
	input wire logic		srst,
	input wire logic [N-1:0]	chan_irq_enable,
	input wire logic		global_irq_enable,
	input wire dmiv_vec_acc_t	vec_acc,
	input wire logic [N-1:0]	chan_done_flag,
	input wire logic [15:0]	irq_vector_word,
	input wire logic		irq_req,
	// Engine and converter side
	input wire dmiv_move_t	move,
	input wire logic [SLOTS-1:0]	conv_result_flag_clr,
	input wire logic		dac_ready_flag_clr
);
	function automatic logic [15:0] vc(logic [N-1:0] p);
		vc = 16'h0000;
		for (int i = N - 1; i >= 0; i--)
			if (p[i])
				vc = 16'(2 * i + 2);
	endfunction
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	AST_SET: assert property (move.valid && move.count_after == 16'h0000 |=>
		chan_done_flag[$past(move.chan)]) else $error("flag not set");
	AST_REQ: assert property (irq_req ==
		($past(global_irq_enable) && |(chan_done_flag & $past(chan_irq_enable)))) else $error("req");
	AST_VEC: assert property (
		irq_vector_word == vc(chan_done_flag & $past(chan_irq_enable))) else $error("vector");
	AST_CLR: assert property ((vec_acc.rd || vec_acc.wr) && irq_vector_word != 0 && !move.valid
		|=> !chan_done_flag[$past(irq_vector_word[4:1]) - 1]) else $error("flag not cleared");
	AST_HOLD: assert property (!vec_acc.rd && !vec_acc.wr && !(move.valid && move.count_after == 0)
		|=> $stable(chan_done_flag)) else $error("flag moved");
	AST_SLOT: assert property (1'b1 |=> conv_result_flag_clr ==
		({15'h0000, $past(move.valid) && $past(move.from_slot)} << $past(move.slot)))
		else $error("slot clear");
	AST_DAC: assert property (1'b1 |=> dac_ready_flag_clr == ($past(move.valid) && $past(move.to_dac)))
		else $error("dac clear");
	AST_RST: assert property (disable iff (1'b0) srst |=>
		chan_done_flag == 0 && irq_vector_word == 0 && !irq_req) else $error("reset state");
endmodule
bind dmiv_top dmiv_top_sva #(.N(N), .SLOTS(SLOTS)) u_sva (.ref_clk(ref_clk), .srst(srst),
	.chan_irq_enable(chan_irq_enable), .global_irq_enable(global_irq_enable), .vec_acc(vec_acc),
	.chan_done_flag(chan_done_flag), .irq_vector_word(irq_vector_word), .irq_req(irq_req),
	.move(move), .conv_result_flag_clr(conv_result_flag_clr),
	.dac_ready_flag_clr(dac_ready_flag_clr));

// >>> dmiv_periph.sv
// Behavioural converter and serial unit flags facing the vector block.
`timescale 1ns/1ps
module dmiv_periph (
	// Clock, reset and clear pulses
	input wire logic		ref_clk,
	input wire logic		srst,
	input wire logic [15:0]	conv_result_flag_clr,
	input wire logic		dac_ready_flag_clr,
	// Flags offered as triggers
	output logic [15:0]		conv_result_flag,
	output logic		dac_ready_flag,
	output logic [1:0]		i2c_flags
);
	integer seed = 32'h7df000db;
	integer r;
	always @(posedge ref_clk) begin
		r = $random(seed);
		conv_result_flag <= srst ? 16'h0000 : (conv_result_flag & ~conv_result_flag_clr)
			| ({15'h0000, r[0]} << r[4:1]);
		dac_ready_flag <= !srst && (dac_ready_flag && !dac_ready_flag_clr || r[5]);
		i2c_flags <= srst ? 2'h0 : r[7:6];
	end
endmodule

// >>> dmiv_top_tb_top.sv
// Self-checking bench for the DMA interrupt vector block.
`timescale 1ns/1ps
module dmiv_top_tb_top;
	import dmiv_pkg::*;
	logic		ref_clk = 1'b0, srst = 1'b1, global_irq_enable = 1'b1, e_irq, e_dac;
	logic [7:0]	chan_irq_enable = 8'hFF, chan_done_flag, fl, pend;
	dmiv_vec_acc_t	vec_acc = '0;
	dmiv_move_t	move = '0;
	logic [1:0]	conv_sequence_mode = 2'h0, i2c;
	logic [3:0]	conv_last_slot = 4'h0, e_trg;
	logic [15:0]	conv_result_flag, conv_result_flag_clr, irq_vector_word, e_vec, e_clr;
	logic		dac_ready_flag, dac_ready_flag_clr, irq_req, conv_trigger, dac_trigger;
	logic		i2c_rx_trigger, i2c_tx_trigger;
	wire		i2c_rx_ready = i2c[1];
	wire		i2c_tx_needed = i2c[0];
	integer		seed = 32'h7df000db, r, failures = 0, check_count = 0;
	dmiv_top DUT (.ref_clk(ref_clk), .srst(srst), .chan_irq_enable(chan_irq_enable),
		.global_irq_enable(global_irq_enable), .vec_acc(vec_acc), .chan_done_flag(chan_done_flag),
		.irq_vector_word(irq_vector_word), .irq_req(irq_req), .move(move),
		.conv_sequence_mode(conv_sequence_mode), .conv_last_slot(conv_last_slot),
		.conv_result_flag(conv_result_flag), .dac_ready_flag(dac_ready_flag),
		.i2c_rx_ready(i2c_rx_ready), .i2c_tx_needed(i2c_tx_needed),
		.conv_result_flag_clr(conv_result_flag_clr), .dac_ready_flag_clr(dac_ready_flag_clr),
		.conv_trigger(conv_trigger), .dac_trigger(dac_trigger), .i2c_rx_trigger(i2c_rx_trigger),
		.i2c_tx_trigger(i2c_tx_trigger));
	dmiv_periph u_periph (.ref_clk(ref_clk), .srst(srst), .conv_result_flag_clr(conv_result_flag_clr),
		.dac_ready_flag_clr(dac_ready_flag_clr), .conv_result_flag(conv_result_flag),
		.dac_ready_flag(dac_ready_flag), .i2c_flags(i2c));
	initial forever #20 ref_clk = ~ref_clk;
	function automatic logic [15:0] code(logic [7:0] p);
		code = 16'h0000;
		for (int i = 7; i >= 0; i--)
			if (p[i])
				code = 16'(2 * i + 2);
	endfunction
	task automatic chk(logic [15:0] got, logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_sim();
		$display("checks=%0d failures=%0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		fl = 8'h00;
		repeat (4) @(posedge ref_clk);
		srst <= 1'b0;
		for (int i = 0; i < 3000; i++) begin
			@(posedge ref_clk);
			pend = fl & chan_irq_enable;
			if (vec_acc.rd | vec_acc.wr)
				fl = fl & ~(pend & -pend);
			if (move.valid && move.count_after == 16'h0000)
				fl[move.chan] = 1'b1;
			pend = srst ? 8'h00 : fl & chan_irq_enable;
			fl = srst ? 8'h00 : fl;
			e_vec = code(pend);
			e_irq = global_irq_enable & |pend;
			e_clr = (move.valid & move.from_slot & !srst) ? 16'h0001 << move.slot : 16'h0000;
			e_dac = move.valid & move.to_dac & !srst;
			e_trg = srst ? 4'h0 : {conv_result_flag[conv_last_slot], dac_ready_flag, i2c};
			r = $random(seed);
			// First eight moves fill every channel, then reads drain them in priority order.
			move <= (i < 8) ? '{1'b1, 3'(7 - i), 16'h0000, 1'b0, 1'b0, 4'h0} :
				'{r[0] && i > 16, r[3:1], r[4] ? 16'h0000 : 16'h0001, r[5], r[6], r[10:7]};
			vec_acc.rd <= i > 7 && i % 32 != 31 && (i < 17 || r[11] & r[12]);
			vec_acc.wr <= i > 16 && i % 32 != 31 && r[13] & r[14];
			chan_irq_enable <= (i % 32 == 31) ? r[23:16] : chan_irq_enable;
			global_irq_enable <= (i % 32 == 31) ? r[24] | r[25] : global_irq_enable;
			srst <= i > 40 && r[31:26] == 6'h00;
			conv_sequence_mode <= r[15:14];
			conv_last_slot <= r[29:26];
			@(negedge ref_clk);
			chk(16'(chan_done_flag), 16'(fl));
			chk(irq_vector_word, e_vec);
			chk(16'(irq_req), 16'(e_irq));
			chk(conv_result_flag_clr, e_clr);
			chk(16'(dac_ready_flag_clr), 16'(e_dac));
			chk(16'({conv_trigger, dac_trigger, i2c_rx_trigger, i2c_tx_trigger}), 16'(e_trg));
		end
		end_sim();
	end
endmodule
